/* File: src/pos_pkg.sv */
// package: register map, field positions, reset values and types of the steering block
package pos_pkg;

    // ************************************************
    // register byte addresses on the apb bus
    // ************************************************
    localparam logic [7:0] POS_ADDR_STEER   = 8'h00;
    localparam logic [7:0] POS_ADDR_SYNCMOD = 8'h04;
    localparam logic [7:0] POS_ADDR_INT     = 8'h08;
    localparam logic [7:0] POS_ADDR_MODE    = 8'h0c;
    localparam logic [7:0] POS_ADDR_PHASE   = 8'h10;
    localparam logic [7:0] POS_ADDR_DUTY    = 8'h14;
    localparam logic [7:0] POS_ADDR_PERIOD  = 8'h18;
    localparam logic [7:0] POS_ADDR_TIMER   = 8'h1c;

    // ************************************************
    // field positions
    // ************************************************
    localparam int POS_SYNC_BIT   = 7;
    localparam int POS_LSMEN_BIT  = 1;
    localparam int POS_HSMEN_BIT  = 0;
    localparam int POS_IE_LSB     = 4;
    localparam int POS_IF_LSB     = 0;

    // ************************************************
    // reset values and time-base maximum
    // ************************************************
    localparam logic [5:0]  POS_STEER_RST   = 6'h01;
    localparam logic [7:0]  POS_SYNCMOD_RST = 8'h00;
    localparam logic [7:0]  POS_INT_RST     = 8'h00;
    localparam logic [3:0]  POS_MODE_RST    = 4'h0;
    localparam logic [15:0] POS_VAL_RST     = 16'h0000;
    localparam logic [15:0] POS_TMR_MAX     = 16'hffff;

    // ************************************************
    // modes and carriers
    // ************************************************
    localparam logic [3:0] POS_MODE_SINGLE = 4'b0000;
    localparam logic [3:0] POS_MODE_COMPL  = 4'b0001;
    localparam logic [3:0] POS_MODE_3PHASE = 4'b1100;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } pos_apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pos_apb_rsp_s;

    typedef struct packed {
        logic pwm;
        logic mod_src;
        logic period_evt;
    } pos_src_s;

endpackage : pos_pkg

/* File: src/pos_steer.sv */
// module: pwm output steering and time-base flag logic with apb registers
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pos_steer
    import pos_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b0,
    parameter int TMR_W           = 16
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // apb slave
    input  wire pos_pkg::pos_apb_req_s apb_req,
    output var  pos_pkg::pos_apb_rsp_s apb_rsp,
    // pwm sources, same clock domain
    input  wire pos_pkg::pos_src_s     src,
    // time base
    input  wire logic [15:0]           timebase_counter,
    // pins and interrupt
    output logic                       out_a,
    output logic                       out_b,
    output logic                       out_c,
    output logic                       out_d,
    output logic                       out_e,
    output logic                       out_f,
    output logic                       irq
);
    import pos_pkg::*;

    initial begin
        if (TMR_W != 16) begin
            $error("pos_steer: time base must be 16 bits wide");
        end
    end

    // ************************************************
    // register state
    // ************************************************
    logic [5:0]  steer_q;
    logic [5:0]  steer_act_q;
    logic        steer_sync_q;
    logic        low_side_mod_en_q;
    logic        high_side_mod_en_q;
    logic [3:0]  irq_en_q;
    logic [3:0]  flag_q;
    logic [3:0]  config_select_q;
    logic [15:0] phase_value_q;
    logic [15:0] duty_value_q;
    logic [15:0] period_value_q;
    logic [15:0] tmr_prev_q;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;

    logic        wr_en;
    logic        rd_en;
    logic [5:0]  steer_mask;
    logic [5:0]  wdata_steer;
    logic [3:0]  evt;

    // second instance has no c..f steering bits
    assign steer_mask  = SECOND_INSTANCE ? 6'h03 : 6'h3f;
    assign wdata_steer = apb_req.pwdata[5:0] & steer_mask;

    // one wait state: pready rises in the second access cycle
    assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite
                 & ~pready_q;
    assign rd_en = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

    // ************************************************
    // control registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            steer_q <= POS_STEER_RST;
        end else if (wr_en && apb_req.paddr == POS_ADDR_STEER) begin
            steer_q <= wdata_steer;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            steer_sync_q       <= POS_SYNCMOD_RST[POS_SYNC_BIT];
            low_side_mod_en_q  <= POS_SYNCMOD_RST[POS_LSMEN_BIT];
            high_side_mod_en_q <= POS_SYNCMOD_RST[POS_HSMEN_BIT];
        end else if (wr_en && apb_req.paddr == POS_ADDR_SYNCMOD) begin
            steer_sync_q       <= apb_req.pwdata[POS_SYNC_BIT];
            low_side_mod_en_q  <= apb_req.pwdata[POS_LSMEN_BIT];
            high_side_mod_en_q <= apb_req.pwdata[POS_HSMEN_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            config_select_q <= POS_MODE_RST;
            phase_value_q   <= POS_VAL_RST;
            duty_value_q    <= POS_VAL_RST;
            period_value_q  <= POS_VAL_RST;
        end else if (wr_en) begin
            if (apb_req.paddr == POS_ADDR_MODE) begin
                config_select_q <= apb_req.pwdata[3:0];
            end
            if (apb_req.paddr == POS_ADDR_PHASE) begin
                phase_value_q <= apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == POS_ADDR_DUTY) begin
                duty_value_q <= apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == POS_ADDR_PERIOD) begin
                period_value_q <= apb_req.pwdata[15:0];
            end
        end
    end

    // ************************************************
    // steering update point
    // ************************************************
    // with sync on, copy waits for the period event so a half period never
    // reaches the switches with a mixed combination
    always_ff @(posedge clk) begin
        if (reset) begin
            steer_act_q <= POS_STEER_RST;
        end else if (!steer_sync_q || src.period_evt) begin
            steer_act_q <= steer_q;
        end
    end

    // ************************************************
    // time-base events and flags
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            tmr_prev_q <= POS_VAL_RST;
        end else begin
            tmr_prev_q <= timebase_counter;
        end
    end

    // match is edge-qualified so a stalled counter flags once
    always_comb begin
        evt[3] = (tmr_prev_q == POS_TMR_MAX)
               && (timebase_counter == POS_VAL_RST);
        evt[2] = (timebase_counter == phase_value_q)
               && (tmr_prev_q != timebase_counter);
        evt[1] = (timebase_counter == duty_value_q)
               && (tmr_prev_q != timebase_counter);
        evt[0] = (timebase_counter == period_value_q)
               && (tmr_prev_q != timebase_counter);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_en_q <= POS_INT_RST[7:4];
        end else if (wr_en && apb_req.paddr == POS_ADDR_INT) begin
            irq_en_q <= apb_req.pwdata[7:POS_IE_LSB];
        end
    end

    // a new event wins over a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            flag_q <= POS_INT_RST[3:0];
        end else if (wr_en && apb_req.paddr == POS_ADDR_INT) begin
            flag_q <= (apb_req.pwdata[3:POS_IF_LSB] & flag_q) | evt;
        end else begin
            flag_q <= flag_q | evt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(flag_q & irq_en_q);
        end
    end

    // ************************************************
    // apb read path
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= apb_req.psel & apb_req.penable & ~pready_q;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (rd_en) begin
            pslverr_q <= 1'b0;
            unique case (apb_req.paddr)
                POS_ADDR_STEER:   prdata_q <= {26'h0, steer_q};
                POS_ADDR_SYNCMOD: prdata_q <= {24'h0, steer_sync_q, 5'h00,
                                     low_side_mod_en_q, high_side_mod_en_q};
                POS_ADDR_INT:     prdata_q <= {24'h0, irq_en_q, flag_q};
                POS_ADDR_MODE:    prdata_q <= {28'h0, config_select_q};
                POS_ADDR_PHASE:   prdata_q <= {16'h0, phase_value_q};
                POS_ADDR_DUTY:    prdata_q <= {16'h0, duty_value_q};
                POS_ADDR_PERIOD:  prdata_q <= {16'h0, period_value_q};
                POS_ADDR_TIMER:   prdata_q <= {16'h0, timebase_counter};
                default: begin
                    prdata_q  <= 32'h0000_0000;
                    pslverr_q <= 1'b1;
                end
            endcase
        end else if (apb_req.psel && !apb_req.penable) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= !(apb_req.paddr <= POS_ADDR_TIMER
                           && apb_req.paddr[1:0] == 2'b00);
        end
    end

    always_comb begin
        apb_rsp.pready  = pready_q;
        apb_rsp.prdata  = prdata_q;
        apb_rsp.pslverr = pslverr_q & pready_q;
    end

    // ************************************************
    // output steering
    // ************************************************
    logic [5:0] lvl;
    logic [5:0] pin_d;

    // 3-phase pairs, bit order f e d c b a; lowest set bit wins
    always_comb begin
        lvl = 6'b000000;
        if (steer_act_q[0]) begin
            lvl = 6'b001001;
        end else if (steer_act_q[1]) begin
            lvl = 6'b100001;
        end else if (steer_act_q[2]) begin
            lvl = 6'b100100;
        end else if (steer_act_q[3]) begin
            lvl = 6'b000110;
        end else if (steer_act_q[4]) begin
            lvl = 6'b010010;
        end else if (steer_act_q[5]) begin
            lvl = 6'b011000;
        end
    end

    always_comb begin
        pin_d = 6'b000000;
        if (config_select_q == POS_MODE_SINGLE) begin
            pin_d = steer_act_q & {6{src.pwm}};
        end else if (config_select_q == POS_MODE_COMPL) begin
            // a, c, e carry true pwm; b, d complementary; f true
            pin_d = steer_act_q & {src.pwm, src.pwm, ~src.pwm,
                                   src.pwm, ~src.pwm, src.pwm};
        end else if (config_select_q == POS_MODE_3PHASE) begin
            pin_d = lvl;
            if (low_side_mod_en_q) begin
                pin_d[1] = lvl[1] & src.mod_src;
                pin_d[3] = lvl[3] & src.mod_src;
                pin_d[5] = lvl[5] & src.mod_src;
            end
            if (high_side_mod_en_q) begin
                pin_d[0] = lvl[0] & src.mod_src;
                pin_d[2] = lvl[2] & src.mod_src;
                pin_d[4] = lvl[4] & src.mod_src;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            {out_f, out_e, out_d, out_c, out_b, out_a} <= 6'b000000;
        end else begin
            {out_f, out_e, out_d, out_c, out_b, out_a} <= pin_d;
        end
    end

endmodule // pos_steer

`default_nettype wire

/* File: test/pos_steer_properties.sv */
// checker: apb timing, decode and reset properties of pos_steer
`timescale 1ns/1ps
`default_nettype none

module pos_steer_properties
    import pos_pkg::*;
(
    // clock and reset
    input wire logic                  clk,
    input wire logic                  reset,
    // register bus
    input wire pos_pkg::pos_apb_req_s apb_req,
    input wire pos_pkg::pos_apb_rsp_s apb_rsp,
    // pins and interrupt
    input wire logic                  out_a,
    input wire logic                  out_b,
    input wire logic                  out_c,
    input wire logic                  out_d,
    input wire logic                  out_e,
    input wire logic                  out_f,
    input wire logic                  irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // ************************************************
    // bus handshake
    // ************************************************
    chk_ready_wait: assert property (apb_req.psel && !apb_req.penable
        |=> !apb_rsp.pready ##1 apb_rsp.pready) else $error("late pready");
    chk_ready_once: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready stretched");
    chk_ready_access: assert property (apb_rsp.pready |-> apb_req.psel
        && apb_req.penable && $past(apb_req.penable))
        else $error("pready outside access");
    chk_err_tied: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
        else $error("pslverr without pready");
    // unaligned or beyond the map must be refused, all else accepted
    chk_err_decode: assert property (apb_rsp.pready |-> apb_rsp.pslverr
        == (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > 8'h1c))
        else $error("wrong decode");
    chk_err_data: assert property (apb_rsp.pready && apb_rsp.pslverr
        |-> apb_rsp.prdata == 32'h0) else $error("refused read data");
    chk_upper_zero: assert property (apb_rsp.pready
        |-> apb_rsp.prdata[31:16] == 16'h0) else $error("upper bits set");
    chk_reset_quiet: assert property ($fell(reset) |-> {out_a, out_b,
        out_c, out_d, out_e, out_f, irq, apb_rsp.pready} == 8'h0)
        else $error("not quiet after reset");

    cover property (apb_rsp.pready && apb_req.pwrite);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
    cover property ($rose(irq));
endmodule // pos_steer_properties

bind pos_steer pos_steer_properties u_props (.clk(clk), .reset(reset),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .out_a(out_a), .out_b(out_b),
    .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f),
    .irq(irq));

`default_nettype wire

/* File: test/pos_switch_model.sv */
// partner: power switch drivers seen as one gate-on vector
`timescale 1ns/1ps
`default_nettype none

module pos_switch_model (
    // pins from the steering block
    input  wire logic  out_a,
    input  wire logic  out_b,
    input  wire logic  out_c,
    input  wire logic  out_d,
    input  wire logic  out_e,
    input  wire logic  out_f,
    // gate state, bit 0 is out_a
    output logic [5:0] gate_on
);
    // drivers are level followers; no dead time is modelled here
    assign gate_on = {out_f, out_e, out_d, out_c, out_b, out_a};
endmodule // pos_switch_model

`default_nettype wire

/* File: test/pos_steer_test.sv */
// testbench: registers, steering, modulation and flags of pos_steer
`timescale 1ns/1ps
`default_nettype none

module pos_steer_test;
    import pos_pkg::*;
    localparam logic [5:0]  PH3 [6] = '{6'h09, 6'h21, 6'h24, 6'h06,
                                        6'h12, 6'h18};
    localparam logic [15:0] SEQ [5] = '{16'h0010, 16'h0020, 16'h0030,
                                        16'hffff, 16'h0000};
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    pos_apb_req_s apb_req = '0;
    pos_apb_rsp_s apb_rsp, rsp2;
    pos_src_s     src = '0;
    logic [15:0]  tbc = 16'h0;
    logic         out_a, out_b, out_c, out_d, out_e, out_f, irq;
    logic [5:0]   gate_on;
    logic [31:0]  rd, rd2;
    logic         er;
    int           errors = 0;
    int           samples_checked = 0;
    int           cycles = 0;

    always #4 clk = ~clk;

    pos_steer #(.SECOND_INSTANCE(1'b0), .TMR_W(16)) DUT (.clk(clk),
        .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp), .src(src),
        .timebase_counter(tbc), .out_a(out_a), .out_b(out_b),
        .out_c(out_c), .out_d(out_d), .out_e(out_e), .out_f(out_f),
        .irq(irq));
    // second instance shares the bus so its narrowed register is seen
    pos_steer #(.SECOND_INSTANCE(1'b1), .TMR_W(16)) DUT2 (.clk(clk),
        .reset(reset), .apb_req(apb_req), .apb_rsp(rsp2), .src(src),
        .timebase_counter(tbc), .out_a(), .out_b(), .out_c(), .out_d(),
        .out_e(), .out_f(), .irq());
    pos_switch_model u_sw (.out_a(out_a), .out_b(out_b), .out_c(out_c),
        .out_d(out_d), .out_e(out_e), .out_f(out_f), .gate_on(gate_on));

    // ************************************************
    // tasks
    // ************************************************
    task automatic chk(input string n, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 50);
        if (n == 50) begin
            errors++;
            stop_test();
        end
        rd = apb_rsp.prdata;
        rd2 = rsp2.prdata;
        er = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task automatic drive(input logic p, input logic m);
        @(posedge clk);
        src <= '{p, m, 1'b0};
    endtask

    // margin covers register, steering and pin stages
    task automatic pins(input string n, input logic [5:0] e);
        repeat (4) @(posedge clk);
        chk(n, {26'h0, gate_on}, {26'h0, e});
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ************************************************
    // tests
    // ************************************************
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        xfer(1'b0, POS_ADDR_STEER, 32'h0);
        chk("steer reset", rd, 32'h1);
        xfer(1'b0, POS_ADDR_SYNCMOD, 32'h0);
        chk("syncmod reset", rd, 32'h0);
        xfer(1'b0, POS_ADDR_INT, 32'h0);
        chk("int reset", rd, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped err", {31'h0, er}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test reset and map done");
        xfer(1'b1, POS_ADDR_MODE, {28'h0, POS_MODE_SINGLE});
        xfer(1'b1, POS_ADDR_STEER, 32'h3f);
        drive(1'b1, 1'b0);
        pins("single on", 6'h3f);
        drive(1'b0, 1'b0);
        pins("single off", 6'h00);
        xfer(1'b1, POS_ADDR_STEER, 32'h05);
        drive(1'b1, 1'b0);
        pins("single part", 6'h05);
        xfer(1'b0, POS_ADDR_STEER, 32'h0);
        chk("steer read", rd, 32'h05);
        chk("steer second", rd2, 32'h01);
        xfer(1'b1, POS_ADDR_SYNCMOD, 32'h3);
        pins("mod ignored", 6'h05);
        xfer(1'b1, POS_ADDR_MODE, {28'h0, POS_MODE_COMPL});
        xfer(1'b1, POS_ADDR_STEER, 32'h3f);
        pins("compl high", 6'h35);
        drive(1'b0, 1'b0);
        pins("compl low", 6'h0a);
        xfer(1'b1, POS_ADDR_STEER, 32'h08);
        pins("compl part", 6'h08);
        $display("test single and complementary done");
        xfer(1'b1, POS_ADDR_SYNCMOD, 32'h0);
        xfer(1'b1, POS_ADDR_MODE, {28'h0, POS_MODE_3PHASE});
        for (int i = 0; i < 6; i++) begin
            xfer(1'b1, POS_ADDR_STEER, 32'h1 << i);
            pins("three phase", PH3[i]);
        end
        xfer(1'b1, POS_ADDR_STEER, 32'h3c);
        pins("lowest wins", PH3[2]);
        xfer(1'b1, POS_ADDR_STEER, 32'h0);
        pins("none set", 6'h00);
        xfer(1'b1, POS_ADDR_STEER, 32'h1);
        xfer(1'b1, POS_ADDR_SYNCMOD, 32'h3);
        pins("mod low", 6'h00);
        drive(1'b0, 1'b1);
        pins("mod high", 6'h09);
        xfer(1'b1, POS_ADDR_SYNCMOD, 32'h1);
        drive(1'b0, 1'b0);
        pins("high side only", 6'h08);
        drive(1'b0, 1'b1);
        xfer(1'b1, POS_ADDR_SYNCMOD, 32'h80);
        xfer(1'b1, POS_ADDR_STEER, 32'h2);
        pins("sync hold", 6'h09);
        @(posedge clk);
        src.period_evt <= 1'b1;
        @(posedge clk);
        src.period_evt <= 1'b0;
        pins("sync apply", 6'h21);
        $display("test three phase done");
        xfer(1'b1, POS_ADDR_PHASE, 32'h10);
        xfer(1'b1, POS_ADDR_DUTY, 32'h20);
        xfer(1'b1, POS_ADDR_PERIOD, 32'h30);
        foreach (SEQ[i]) begin
            @(posedge clk);
            tbc <= SEQ[i];
        end
        xfer(1'b0, POS_ADDR_INT, 32'h0);
        chk("all flags", rd, 32'h0f);
        xfer(1'b0, POS_ADDR_TIMER, 32'h0);
        chk("timer read", rd, {16'h0, SEQ[4]});
        chk("irq masked", {31'h0, irq}, 32'h0);
        xfer(1'b1, POS_ADDR_INT, 32'h8f);
        repeat (3) @(posedge clk);
        chk("irq overflow", {31'h0, irq}, 32'h1);
        xfer(1'b1, POS_ADDR_INT, 32'h87);
        repeat (3) @(posedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        xfer(1'b0, POS_ADDR_INT, 32'h0);
        chk("flags kept", rd, 32'h87);
        xfer(1'b1, POS_ADDR_INT, 32'h27);
        repeat (3) @(posedge clk);
        chk("irq duty", {31'h0, irq}, 32'h1);
        $display("test flags done");
        stop_test();
    end
endmodule // pos_steer_test

`default_nettype wire
